// ### absolute_home_position_tracker.sv
// Absolute home reference store and position feedback rebuild behind an APB slave.
`timescale 1ns/1ns
`default_nettype none

module absolute_home_position_tracker #(
    parameter int TURN_W = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic [TURN_W-1:0] enc_turns,
    input  wire logic [31:0]       enc_fraction,
    input  wire logic              enc_fault,
    input  wire logic              home_start,
    input  wire logic              home_done,
    input  wire logic [31:0]       home_end_position,
    input  wire logic              power_up,
    input  wire logic              warm_start,
    input  wire logic              reboot,
    input  wire logic              power_down,
    input  wire logic              config_download,
    output logic                   home_established_flag,
    output logic                   position_valid_flag,
    output logic [31:0]            position_feedback,
    output logic                   irq
);

    localparam int FULL_W = TURN_W + abs_home_pkg::FRAC_W;
    localparam int DW     = abs_home_pkg::DEC_W;
    localparam int IW     = abs_home_pkg::IRQ_W;

    // -------------------------------------------------------------------
    // Turn scaling
    // -------------------------------------------------------------------
    // Turns in 2^-32 steps times user units per turn, integer part kept.
    function automatic logic [31:0] scale_turns(
        input logic [FULL_W-1:0] d,
        input logic              sgn,
        input logic [31:0]       upt
    );
        logic [FULL_W+31:0] ext_d;
        logic [FULL_W+31:0] prod;
        ext_d = {{32{sgn & d[FULL_W-1]}}, d};
        prod  = ext_d * {{FULL_W{1'b0}}, upt};
        return prod[63:32];
    endfunction

    // -------------------------------------------------------------------
    // Encoder pin synchronisers
    // -------------------------------------------------------------------
    // The encoder must hold its word steady for two clocks around a load.
    logic [TURN_W-1:0] turns_meta;
    logic [TURN_W-1:0] turns_sync;
    logic [31:0]       frac_meta;
    logic [31:0]       frac_sync;
    logic              fault_meta;
    logic              fault_sync;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            turns_meta <= '0;
            turns_sync <= '0;
            frac_meta  <= '0;
            frac_sync  <= '0;
            fault_meta <= 1'b0;
            fault_sync <= 1'b0;
        end else if (clk_en) begin
            turns_meta <= enc_turns;
            turns_sync <= turns_meta;
            frac_meta  <= enc_fraction;
            frac_sync  <= frac_meta;
            fault_meta <= enc_fault;
            fault_sync <= fault_meta;
        end
    end

    // -------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------
    logic              auto_recompute_enable;
    logic              range_split_select;
    logic [DW-1:0]     dist_decimal_count;
    logic [31:0]       units_per_turn;
    logic [31:0]       here_position;
    logic [IW-1:0]     irq_enable;
    logic [IW-1:0]     irq_status;
    logic [DW-1:0]     home_decimal_count;
    logic [31:0]       home_position_scaled;
    logic [TURN_W-1:0] home_turn_count;
    logic [31:0]       home_turn_fraction;

    // -------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------
    wire apb_setup = psel & ~penable;
    wire apb_wr    = psel & penable & pwrite & pready;

    wire sel_ctrl  = paddr == abs_home_pkg::OFF_CTRL;
    wire sel_cmd   = paddr == abs_home_pkg::OFF_CMD;
    wire sel_here  = paddr == abs_home_pkg::OFF_HERE_POS;
    wire sel_units = paddr == abs_home_pkg::OFF_UNITS;
    wire sel_iclr  = paddr == abs_home_pkg::OFF_IRQ_CLR;
    wire sel_ien   = paddr == abs_home_pkg::OFF_IRQ_EN;

    wire [31:0] ctrl_word = {{(32 - abs_home_pkg::CTRL_DEC_LSB - DW){1'b0}},
                             dist_decimal_count, 6'h00,
                             range_split_select, auto_recompute_enable};

    wire [31:0] status_word = {30'h0000_0000, position_valid_flag,
                               home_established_flag};

    wire [31:0] rd_mux =
        (paddr == abs_home_pkg::OFF_CTRL)      ? ctrl_word :
        (paddr == abs_home_pkg::OFF_STATUS)    ? status_word :
        (paddr == abs_home_pkg::OFF_HOME_DEC)  ? {{(32 - DW){1'b0}}, home_decimal_count} :
        (paddr == abs_home_pkg::OFF_HOME_POS)  ? home_position_scaled :
        (paddr == abs_home_pkg::OFF_HOME_TURN) ? {{(32 - TURN_W){1'b0}}, home_turn_count} :
        (paddr == abs_home_pkg::OFF_HOME_FRAC) ? home_turn_fraction :
        (paddr == abs_home_pkg::OFF_FEEDBACK)  ? position_feedback :
        (paddr == abs_home_pkg::OFF_HERE_POS)  ? here_position :
        (paddr == abs_home_pkg::OFF_UNITS)     ? units_per_turn :
        (paddr == abs_home_pkg::OFF_IRQ_STAT)  ? {{(32 - IW){1'b0}}, irq_status} :
        (paddr == abs_home_pkg::OFF_IRQ_EN)    ? {{(32 - IW){1'b0}}, irq_enable} :
                                                 abs_home_pkg::ZERO32;

    wire addr_hit = sel_ctrl | sel_cmd | sel_here | sel_units | sel_iclr | sel_ien
                  | (paddr == abs_home_pkg::OFF_STATUS)
                  | (paddr == abs_home_pkg::OFF_HOME_DEC)
                  | (paddr == abs_home_pkg::OFF_HOME_POS)
                  | (paddr == abs_home_pkg::OFF_HOME_TURN)
                  | (paddr == abs_home_pkg::OFF_HOME_FRAC)
                  | (paddr == abs_home_pkg::OFF_FEEDBACK)
                  | (paddr == abs_home_pkg::OFF_IRQ_STAT);

    // -------------------------------------------------------------------
    // Home, validity and load events
    // -------------------------------------------------------------------
    wire cmd_wr     = apb_wr & sel_cmd;
    wire here_cmd   = cmd_wr & pwdata[abs_home_pkg::CMD_HERE];
    wire forget_cmd = cmd_wr & pwdata[abs_home_pkg::CMD_FORGET];
    wire reload_cmd = cmd_wr & pwdata[abs_home_pkg::CMD_RELOAD];

    wire home_event = home_done | here_cmd;
    wire capture    = auto_recompute_enable & home_event;
    wire valid_clr  = reboot | fault_sync | power_down | home_start;
    wire load_req   = power_up | warm_start | reload_cmd;
    wire use_home   = auto_recompute_enable & home_established_flag;

    wire [31:0] capture_pos = here_cmd ? here_position : home_end_position;

    // A home with auto recompute on sets the flag; the forget command alone clears it, and loses a tie.
    wire next_established = capture | (home_established_flag & ~forget_cmd);

    wire next_valid = home_event | (position_valid_flag & ~valid_clr);

    // -------------------------------------------------------------------
    // Feedback rebuild
    // -------------------------------------------------------------------
    wire [FULL_W-1:0] enc_full  = {turns_sync, frac_sync};
    wire [FULL_W-1:0] home_full = {home_turn_count, home_turn_fraction};

    // Modulo subtraction wraps at the encoder range in either mode.
    wire [FULL_W-1:0] home_delta = enc_full - home_full;

    // One-sided reads the offset unsigned; two-sided reads it signed.
    wire [31:0] homed_fb = home_position_scaled
                         + scale_turns(home_delta, range_split_select,
                                       units_per_turn);

    wire [31:0] raw_fb = scale_turns(enc_full, 1'b0, units_per_turn);

    // Stored reference counts only once established and auto recompute is on.
    wire [31:0] load_fb = use_home ? homed_fb : raw_fb;

    wire [31:0] next_feedback = capture  ? capture_pos :
                                load_req ? load_fb : position_feedback;

    // -------------------------------------------------------------------
    // Interrupt status
    // -------------------------------------------------------------------
    wire [IW-1:0] irq_event = {load_req, position_valid_flag & valid_clr & ~home_event, capture};
    wire [IW-1:0] irq_clr   = (apb_wr & sel_iclr) ? pwdata[IW-1:0] : '0;
    wire [IW-1:0] next_irq_status = irq_event | (irq_status & ~irq_clr);
    wire [IW-1:0] next_irq_enable = (apb_wr & sel_ien) ? pwdata[IW-1:0] : irq_enable;

    // -------------------------------------------------------------------
    // APB slave response
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= abs_home_pkg::ZERO32;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= apb_setup;
            pslverr <= apb_setup & ~addr_hit;
            if (apb_setup) begin
                prdata <= rd_mux;
            end
        end
    end

    // -------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------
    // A download restores configuration only; home reference is untouched.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_recompute_enable <= 1'b0;
            range_split_select    <= 1'b0;
            dist_decimal_count    <= abs_home_pkg::DEC_RST;
            units_per_turn        <= abs_home_pkg::UNITS_RST;
            here_position         <= abs_home_pkg::ZERO32;
        end else if (clk_en) begin
            if (config_download) begin
                auto_recompute_enable <= 1'b0;
                range_split_select    <= 1'b0;
                dist_decimal_count    <= abs_home_pkg::DEC_RST;
                units_per_turn        <= abs_home_pkg::UNITS_RST;
                here_position         <= abs_home_pkg::ZERO32;
            end else if (apb_wr) begin
                if (sel_ctrl) begin
                    auto_recompute_enable <= pwdata[abs_home_pkg::CTRL_AUTO];
                    range_split_select    <= pwdata[abs_home_pkg::CTRL_TWO];
                    dist_decimal_count    <= pwdata[abs_home_pkg::CTRL_DEC_LSB +: DW];
                end
                if (sel_units) begin
                    units_per_turn <= pwdata;
                end
                if (sel_here) begin
                    here_position <= pwdata;
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Home reference store
    // -------------------------------------------------------------------
    // Nothing but a capture writes these, so downloads leave them alone.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            home_decimal_count   <= abs_home_pkg::DEC_RST;
            home_position_scaled <= abs_home_pkg::ZERO32;
            home_turn_count      <= '0;
            home_turn_fraction   <= abs_home_pkg::ZERO32;
        end else if (clk_en && capture) begin
            home_decimal_count   <= dist_decimal_count;
            home_position_scaled <= capture_pos;
            home_turn_count      <= turns_sync;
            home_turn_fraction   <= frac_sync;
        end
    end

    // -------------------------------------------------------------------
    // Flags, feedback and interrupt
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            home_established_flag <= 1'b0;
            position_valid_flag   <= 1'b0;
            position_feedback     <= abs_home_pkg::ZERO32;
            irq_status            <= '0;
            irq_enable            <= '0;
            irq                   <= 1'b0;
        end else if (clk_en) begin
            home_established_flag <= next_established;
            position_valid_flag   <= next_valid;
            position_feedback     <= next_feedback;
            irq_status            <= next_irq_status;
            irq_enable            <= next_irq_enable;
            irq                   <= |(next_irq_status & next_irq_enable);
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_home_sets_flag;
        clk_en && auto_recompute_enable && home_event |=> home_established_flag;
    endproperty
    a_home_sets_flag: assert property (p_home_sets_flag)
        else $error("home did not set the established flag");

    property p_flag_kept;
        home_established_flag && !(clk_en && forget_cmd) |=> home_established_flag;
    endproperty
    a_flag_kept: assert property (p_flag_kept)
        else $error("established flag dropped without forget");

    property p_homed_load;
        clk_en && load_req && !capture && use_home |=> position_feedback == $past(homed_fb);
    endproperty
    a_homed_load: assert property (p_homed_load)
        else $error("homed load did not use stored reference");

    property p_unhomed_load;
        clk_en && load_req && !capture && !home_established_flag
            |=> position_feedback == $past(raw_fb);
    endproperty
    a_unhomed_load: assert property (p_unhomed_load)
        else $error("unhomed load used stored reference");

    property p_auto_off_load;
        clk_en && load_req && !auto_recompute_enable |=> position_feedback == $past(raw_fb);
    endproperty
    a_auto_off_load: assert property (p_auto_off_load)
        else $error("load with recompute off not raw");

    property p_capture_refs;
        clk_en && capture |=> home_decimal_count == $past(dist_decimal_count)
            && home_turn_count == $past(turns_sync)
            && home_turn_fraction == $past(frac_sync);
    endproperty
    a_capture_refs: assert property (p_capture_refs)
        else $error("home reference capture wrong");

    property p_capture_pos;
        clk_en && capture && !here_cmd |=> home_position_scaled == $past(home_end_position);
    endproperty
    a_capture_pos: assert property (p_capture_pos)
        else $error("end-of-home position not stored");

    property p_download_keeps;
        config_download && !capture |=> $stable(home_position_scaled)
            && $stable(home_turn_count) && $stable(home_turn_fraction);
    endproperty
    a_download_keeps: assert property (p_download_keeps)
        else $error("download altered home reference");

    property p_valid_set;
        clk_en && home_event |=> position_valid_flag;
    endproperty
    a_valid_set: assert property (p_valid_set)
        else $error("position valid not raised");

    property p_valid_clear;
        clk_en && valid_clr && !home_event |=> !position_valid_flag;
    endproperty
    a_valid_clear: assert property (p_valid_clear)
        else $error("position valid not cleared");

    property p_apb_one_wait;
        clk_en && apb_setup |=> pready;
    endproperty
    a_apb_one_wait: assert property (p_apb_one_wait)
        else $error("apb answer missing after setup");

endmodule
`default_nettype wire

// ### abs_home_pkg.sv
// Constants and register map of the absolute home position tracker.
// Operation
// - With auto recompute on, a completed home sets the established flag until the forget command clears it.
// - While established with auto recompute on, feedback comes from encoder position plus stored home reference.
// - While not established, loading feedback ignores any stored home reference.
// - Established flag survives downloads; only the forget command clears it.
// - Capture the decimal count at home; the feedback rebuild does not use it.
// - Store scaled home position: end-of-home position or home-here position.
// - Store the encoder whole-turn count at home as offset.
// - Store the encoder turn fraction at home, in units of 2^-32 turn.
// - A configuration download leaves all stored home reference values intact.
// - Home-here or a successful home raises the position-valid flag.
// - Reboot, encoder fault, power-down or a new home clear position-valid.
// - With auto recompute off, load feedback straight from the encoder.
// - With auto recompute on and homed, rebuild feedback using the range mode.
// - One-sided mode places the whole encoder range above home.
// - Two-sided mode splits the encoder range evenly around home.
package abs_home_pkg;

    localparam int FRAC_W = 32;
    localparam int DEC_W  = 4;
    localparam int IRQ_W  = 3;

    // -------------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_CMD       = 8'h04;
    localparam logic [7:0] OFF_STATUS    = 8'h08;
    localparam logic [7:0] OFF_HOME_DEC  = 8'h0c;
    localparam logic [7:0] OFF_HOME_POS  = 8'h10;
    localparam logic [7:0] OFF_HOME_TURN = 8'h14;
    localparam logic [7:0] OFF_HOME_FRAC = 8'h18;
    localparam logic [7:0] OFF_FEEDBACK  = 8'h1c;
    localparam logic [7:0] OFF_HERE_POS  = 8'h20;
    localparam logic [7:0] OFF_UNITS     = 8'h24;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h28;
    localparam logic [7:0] OFF_IRQ_CLR   = 8'h2c;
    localparam logic [7:0] OFF_IRQ_EN    = 8'h30;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int CTRL_AUTO    = 0;
    localparam int CTRL_TWO     = 1;
    localparam int CTRL_DEC_LSB = 8;
    localparam int CMD_HERE     = 0;
    localparam int CMD_FORGET   = 1;
    localparam int CMD_RELOAD   = 2;
    localparam int ST_HOMED     = 0;
    localparam int ST_VALID     = 1;
    localparam int IRQ_HOMED    = 0;
    localparam int IRQ_LOST     = 1;
    localparam int IRQ_LOADED   = 2;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [DEC_W-1:0] DEC_RST   = 4'h3;
    localparam logic [31:0]      UNITS_RST = 32'h0000_2710;
    localparam logic [31:0]      ZERO32    = 32'h0000_0000;

endpackage

// ### abs_encoder_model.sv
// Behavioural multi-turn absolute encoder that presents a commanded position.
`timescale 1ns/1ns
`default_nettype none

module abs_encoder_model #(
    parameter int TURN_W = 16
) (
    input  wire logic [TURN_W+31:0] target,
    input  wire logic               pclk,
    input  wire logic               fault_req,
    output logic      [TURN_W-1:0]  enc_turns,
    output logic      [31:0]        enc_fraction,
    output logic                    enc_fault
);
    // The reading and the fault line follow the command one clock later.
    always_ff @(posedge pclk) begin
        {enc_turns, enc_fraction} <= target;
        enc_fault                 <= fault_req;
    end
endmodule

`default_nettype wire

// ### absolute_home_position_tracker_test.sv
// Self-checking bench for the absolute home position tracker.
`timescale 1ns/1ns
`default_nettype none

module absolute_home_position_tracker_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, est, valid, e, flt;
    logic [7:0]  paddr, ev;
    logic [31:0] pwdata, prdata, fbo, hend, rd, m_units, m_hpos, frac;
    logic [15:0] turns;
    logic [47:0] tgt, p0, p1, m_henc;
    bit          m_auto, m_est;
    int          err_total, compares, seed;
    int          evs[4] = '{0, 4, 5, 7};

    absolute_home_position_tracker i_absolute_home_position_tracker (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .enc_turns(turns), .enc_fraction(frac), .enc_fault(flt),
        .home_start(ev[0]), .home_done(ev[1]), .home_end_position(hend), .power_up(ev[2]),
        .warm_start(ev[3]), .reboot(ev[4]), .power_down(ev[5]), .config_download(ev[6]),
        .home_established_flag(est), .position_valid_flag(valid),
        .position_feedback(fbo), .irq(irq));

    abs_encoder_model i_abs_encoder_model (
        .target(tgt), .pclk(pclk), .fault_req(ev[7]), .enc_turns(turns),
        .enc_fraction(frac), .enc_fault(flt));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // Setup cycle, then access phase held until pready is sampled high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            err_total++;
            complete_run();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic pulse(input int b);
        @(posedge pclk);
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev <= 8'h00;
        repeat (4) @(posedge pclk);
        #1;
    endtask

    task automatic move(input logic [47:0] p, input logic [31:0] h);
        @(posedge pclk);
        tgt <= p; hend <= h;
        repeat (4) @(posedge pclk);
    endtask

    function automatic logic [31:0] fb(input logic [47:0] enc, input bit two);
        logic [47:0] x;
        logic [95:0] p;
        bit          use_ref;
        use_ref = m_auto && m_est;
        x = enc - (use_ref ? m_henc : 48'h0);
        p = ((use_ref && two && x[47]) ? {48'hffff_ffff_ffff, x} : {48'h0, x}) * {64'h0, m_units};
        return (use_ref ? m_hpos : 32'h0) + p[63:32];
    endfunction

    initial begin
        seed = 85; err_total = 0; compares = 0; m_auto = 0; m_est = 0;
        presetn = 1'b0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
        ev = 8'h00; tgt = 48'h0; hend = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, abs_home_pkg::OFF_CTRL, 32'h0); check(rd, 32'h0000_0300);
        apb(0, abs_home_pkg::OFF_UNITS, 32'h0); check(rd, 32'h0000_2710);
        apb(0, 8'h34, 32'h0); check(32'(e), 32'h1);
        m_units = ($random(seed) & 32'h00ff_ffff) | 32'h1;
        apb(1, abs_home_pkg::OFF_UNITS, m_units);
        apb(1, abs_home_pkg::OFF_CTRL, 32'h0000_0501); m_auto = 1;
        p0 = {$random(seed), $random(seed)}; m_hpos = $random(seed);
        move(p0, m_hpos);
        pulse(1); m_henc = p0; m_est = 1;
        check(32'(est), 32'h1);
        check(32'(valid), 32'h1);
        apb(0, abs_home_pkg::OFF_HOME_TURN, 32'h0); check(rd, {16'h0, p0[47:32]});
        apb(0, abs_home_pkg::OFF_HOME_FRAC, 32'h0); check(rd, p0[31:0]);
        apb(0, abs_home_pkg::OFF_HOME_POS, 32'h0); check(rd, m_hpos);
        apb(0, abs_home_pkg::OFF_HOME_DEC, 32'h0); check(rd, 32'h5);
        for (int two = 0; two < 2; two++) begin
            apb(1, abs_home_pkg::OFF_CTRL, 32'h0000_0301 | (two << 1));
            p1 = p0 + {{16{two[0]}}, $random(seed)};
            move(p1, hend);
            pulse(3); check(fbo, fb(p1, two[0]));
        end
        pulse(6); m_auto = 0; m_units = 32'h2710;
        check(32'(est), 32'h1);
        apb(0, abs_home_pkg::OFF_HOME_POS, 32'h0); check(rd, m_hpos);
        apb(0, abs_home_pkg::OFF_CTRL, 32'h0); check(rd, 32'h0000_0300);
        pulse(2); check(fbo, fb(p1, 0));
        apb(1, abs_home_pkg::OFF_IRQ_EN, 32'h2);
        foreach (evs[i]) begin
            apb(1, abs_home_pkg::OFF_CMD, 32'h1); check(32'(valid), 32'h1);
            pulse(evs[i]); check(32'(valid), 32'h0);
            check(32'(irq), 32'h1);
            apb(0, abs_home_pkg::OFF_IRQ_STAT, 32'h0); check(rd & 32'h2, 32'h2);
            apb(1, abs_home_pkg::OFF_IRQ_CLR, 32'h2); check(32'(irq), 32'h0);
        end
        apb(1, abs_home_pkg::OFF_CTRL, 32'h0000_0301); m_auto = 1;
        apb(1, abs_home_pkg::OFF_CMD, 32'h2); m_est = 0;
        check(32'(est), 32'h0);
        pulse(3); check(fbo, fb(p1, 0));
        m_hpos = $random(seed);
        apb(1, abs_home_pkg::OFF_HERE_POS, m_hpos);
        apb(1, abs_home_pkg::OFF_CMD, 32'h1);
        m_est = 1;
        m_henc = p1;
        check(32'(est), 32'h1);
        apb(0, abs_home_pkg::OFF_HOME_POS, 32'h0); check(rd, m_hpos);
        apb(0, abs_home_pkg::OFF_FEEDBACK, 32'h0); check(rd, m_hpos);
        apb(0, abs_home_pkg::OFF_STATUS, 32'h0); check(rd, 32'h3);
        move(p0, hend);
        apb(1, abs_home_pkg::OFF_CMD, 32'h4); check(fbo, fb(p0, 0));
        complete_run();
    end
endmodule

`default_nettype wire
